// *** src/mpra_defines.vh ***
// Constants shared by the protection-region attribute block.
`ifndef MPRA_DEFINES_VH
`define MPRA_DEFINES_VH

// Origin register layout.
`define MPRA_BASE_LSB 6
`define MPRA_BASE_MSB 30
`define MPRA_BASE_W 25
`define MPRA_ORG_TYPE_BIT 0
`define MPRA_ORG_IDX_LSB 1
`define MPRA_IDX_W 5

// Attribute register layout.
`define MPRA_ACC_TOP 31
`define MPRA_ACC_WR_BIT 0
`define MPRA_ACC_RD_BIT 1
`define MPRA_ACC_ACCESS_RIGHTS_LSB 2
`define MPRA_ACC_ACCESS_RIGHTS_MSB 4
`define MPRA_ACC_CACHE_BIT 5
`define MPRA_ACC_SIZE_LSB 6
`define MPRA_ACC_SIZE_MSB 30
`define MPRA_SIZE_W 25
`define MPRA_LIMIT_W 26
`define MPRA_ACCESS_RIGHTS_W 3
`define MPRA_CACHE_BYPASS_BIT 31

// Instruction-region access rights codes.
`define MPRA_IPERM_NONE 3'h0
`define MPRA_IPERM_SUP 3'h1
`define MPRA_IPERM_ALL 3'h2

// Data-region access rights codes.
`define MPRA_DPERM_NONE 3'h0
`define MPRA_DPERM_SRD 3'h1
`define MPRA_DPERM_ARD 3'h2
`define MPRA_DPERM_SRW 3'h4
`define MPRA_DPERM_SRW_URD 3'h5
`define MPRA_DPERM_ARW 3'h6

// Reset values.
`define MPRA_RESET_WORD 32'h0000_0000

`endif

// *** src/mpra_access_rights_dec.v ***
// Access rights decoder for one region type.
`timescale 1ns/1ns
`default_nettype none
`include "mpra_defines.vh"

module mpra_access_rights_dec (
	input wire is_data, // High for a data region.
	input wire [2:0] access_rights, // Stored access rights code.
	input wire user_mode, // High when the access is in user mode.
	input wire is_write, // High for a data write.
	output reg allow // High when the access is permitted.
);

	// ****************************************
	// Decode of rights against mode and kind.
	// ****************************************
	always @* begin
		allow = 1'b0;
		if (is_data) begin
			case (access_rights)
				`MPRA_DPERM_SRD: allow = !user_mode && !is_write;
				`MPRA_DPERM_ARD: allow = !is_write;
				`MPRA_DPERM_SRW: allow = !user_mode;
				`MPRA_DPERM_SRW_URD: allow = !user_mode || !is_write;
				`MPRA_DPERM_ARW: allow = 1'b1;
				default: allow = 1'b0; // None, or reserved and undefined.
			endcase
		end else begin
			case (access_rights)
				`MPRA_IPERM_SUP: allow = !user_mode;
				`MPRA_IPERM_ALL: allow = 1'b1;
				default: allow = 1'b0; // None, or reserved and undefined.
			endcase
		end
	end

endmodule // mpra_access_rights_dec
`default_nettype wire

// *** src/mpra_attr.v ***
// Protection region attribute register, region table and access check.
`timescale 1ns/1ns
`default_nettype none
`include "mpra_defines.vh"

module mpra_attr #(
	parameter USE_LIMIT = 0, // 1 selects the limit variant, 0 the mask variant.
	parameter NUM_DREG = 32, // Number of data regions.
	parameter NUM_IREG = 32, // Number of instruction regions.
	parameter MIN_SHIFT = 6, // Log2 of the minimum region size in bytes.
	parameter ADDR_W = 31 // Width of the byte address space.
) (
	input wire sys_clk, // Processor clock.
	input wire rst, // Synchronous reset, active high.
	input wire org_wr, // Control-store strobe to the origin register.
	input wire acc_wr, // Control-store strobe to the attribute register.
	input wire [31:0] ctl_wdata, // Control-store data.
	output reg [31:0] org_rdata, // Origin register read value.
	output reg [31:0] acc_rdata, // Attribute register read value.
	input wire [31:0] d_addr, // Data access byte address.
	input wire d_write, // Data access is a store.
	input wire d_uncached_op, // Access from an uncached load or store.
	input wire i_user, // Data and fetch access in user mode.
	input wire [31:0] i_addr, // Instruction fetch byte address.
	input wire dcache_present, // High when a data cache exists.
	output reg d_allow, // Data access permitted by a matching region.
	output reg d_cacheable, // Data access may be cached.
	output reg i_allow // Fetch permitted by a matching region.
);

	// ****************************************
	// Field masks from the build options.
	// ****************************************
	localparam [`MPRA_BASE_W-1:0] LOW_ZERO = {`MPRA_BASE_W{1'b1}} << (MIN_SHIFT - `MPRA_BASE_LSB);
	localparam [`MPRA_BASE_W-1:0] HIGH_KEEP = {`MPRA_BASE_W{1'b1}} >> (`MPRA_BASE_MSB + 1 - ADDR_W);
	localparam [`MPRA_BASE_W-1:0] FIELD_KEEP = LOW_ZERO & HIGH_KEEP; // Implemented base bits.
	localparam [`MPRA_LIMIT_W-1:0] LIM_KEEP = {1'b1, FIELD_KEEP}; // Implemented limit bits.
	localparam DIDX_W = (NUM_DREG > 1) ? $clog2(NUM_DREG) : 1; // Data index width.

	// ****************************************
	// Software-visible registers.
	// ****************************************
	reg [`MPRA_BASE_W-1:0] base_reg; // Region base, address bits 30 to 6.
	reg [`MPRA_IDX_W-1:0] index_reg; // Selected region index.
	reg type_reg; // High selects the data region set.
	reg [`MPRA_LIMIT_W-1:0] size_reg; // Mask or limit, limit uses the top bit.
	reg cache_reg; // Fill-allowed flag.
	reg [`MPRA_ACCESS_RIGHTS_W-1:0] rights_reg; // Access rights.

	// ****************************************
	// Region table storage.
	// ****************************************
	reg [`MPRA_BASE_W-1:0] d_base_mem [0:NUM_DREG-1]; // Data region bases.
	reg [`MPRA_LIMIT_W-1:0] d_size_mem [0:NUM_DREG-1]; // Data region size or limit.
	reg [NUM_DREG-1:0] d_cache_mem; // Data region fill-allowed flags.
	reg [`MPRA_ACCESS_RIGHTS_W-1:0] d_access_rights_mem [0:NUM_DREG-1]; // Data region rights.
	reg [NUM_DREG-1:0] d_valid_reg; // Data entries written since reset.
	reg [`MPRA_BASE_W-1:0] i_base_mem [0:NUM_IREG-1]; // Instruction region bases.
	reg [`MPRA_LIMIT_W-1:0] i_size_mem [0:NUM_IREG-1]; // Instruction region size or limit.
	reg [`MPRA_ACCESS_RIGHTS_W-1:0] i_access_rights_mem [0:NUM_IREG-1]; // Instruction region rights.
	reg [NUM_IREG-1:0] i_valid_reg; // Instruction entries written since reset.

	wire fetch_trig = acc_wr && ctl_wdata[`MPRA_ACC_RD_BIT]; // Region read request.
	wire store_trig = acc_wr && ctl_wdata[`MPRA_ACC_WR_BIT]; // Region write request.
	wire [`MPRA_LIMIT_W-1:0] wr_size; // Size or limit as written, trimmed.
	wire [`MPRA_BASE_W-1:0] new_base; // Base as written, trimmed.
	wire sel_d_ok = (index_reg < NUM_DREG); // Index falls in data set.
	wire sel_i_ok = (index_reg < NUM_IREG); // Index falls in instruction set.
	integer k; // Loop variable.

	assign wr_size = (USE_LIMIT != 0) ?
		(ctl_wdata[`MPRA_ACC_TOP:`MPRA_ACC_SIZE_LSB] & LIM_KEEP) :
		{1'b0, ctl_wdata[`MPRA_ACC_SIZE_MSB:`MPRA_ACC_SIZE_LSB] & FIELD_KEEP};
	// base is address bits 30 to 6.
	assign new_base = ctl_wdata[`MPRA_BASE_MSB:`MPRA_BASE_LSB] & FIELD_KEEP;

	// ****************************************
	// Register updates and region transfers.
	// ****************************************
	always @(posedge sys_clk) begin
		if (rst) begin
			base_reg <= {`MPRA_BASE_W{1'b0}};
			index_reg <= {`MPRA_IDX_W{1'b0}};
			type_reg <= 1'b0;
			size_reg <= {`MPRA_LIMIT_W{1'b0}};
			cache_reg <= 1'b0;
			rights_reg <= {`MPRA_ACCESS_RIGHTS_W{1'b0}};
			d_valid_reg <= {NUM_DREG{1'b0}};
			i_valid_reg <= {NUM_IREG{1'b0}};
		end else begin
			// Origin register write.
			if (org_wr) begin
				base_reg <= new_base;
				index_reg <= ctl_wdata[`MPRA_ORG_IDX_LSB+`MPRA_IDX_W-1:`MPRA_ORG_IDX_LSB];
				type_reg <= ctl_wdata[`MPRA_ORG_TYPE_BIT];
			end
			if (acc_wr && !fetch_trig) begin
				// Plain write, or store trigger which also stores the fields.
				size_reg <= wr_size;
				cache_reg <= type_reg & ctl_wdata[`MPRA_ACC_CACHE_BIT];
				rights_reg <= ctl_wdata[`MPRA_ACC_ACCESS_RIGHTS_MSB:`MPRA_ACC_ACCESS_RIGHTS_LSB];
			end
			if (store_trig && !fetch_trig) begin
				if (type_reg && sel_d_ok) begin
					d_base_mem[index_reg[DIDX_W-1:0]] <= base_reg;
					d_size_mem[index_reg[DIDX_W-1:0]] <= wr_size;
					d_cache_mem[index_reg[DIDX_W-1:0]] <= ctl_wdata[`MPRA_ACC_CACHE_BIT];
					d_access_rights_mem[index_reg[DIDX_W-1:0]] <=
						ctl_wdata[`MPRA_ACC_ACCESS_RIGHTS_MSB:`MPRA_ACC_ACCESS_RIGHTS_LSB];
					d_valid_reg[index_reg[DIDX_W-1:0]] <= 1'b1;
				end else if (!type_reg && sel_i_ok) begin
					i_base_mem[index_reg] <= base_reg;
					i_size_mem[index_reg] <= wr_size;
					i_access_rights_mem[index_reg] <= ctl_wdata[`MPRA_ACC_ACCESS_RIGHTS_MSB:`MPRA_ACC_ACCESS_RIGHTS_LSB];
					i_valid_reg[index_reg] <= 1'b1;
				end
			end
			if (fetch_trig) begin
				if (type_reg && sel_d_ok) begin
					base_reg <= d_base_mem[index_reg[DIDX_W-1:0]];
					size_reg <= d_size_mem[index_reg[DIDX_W-1:0]];
					cache_reg <= d_cache_mem[index_reg[DIDX_W-1:0]];
					rights_reg <= d_access_rights_mem[index_reg[DIDX_W-1:0]];
				end else if (!type_reg && sel_i_ok) begin
					base_reg <= i_base_mem[index_reg];
					size_reg <= i_size_mem[index_reg];
					cache_reg <= 1'b0;
					rights_reg <= i_access_rights_mem[index_reg];
				end
			end
		end
	end

	// ****************************************
	// Control-load read values.
	// ****************************************
	always @* begin
		org_rdata = `MPRA_RESET_WORD;
		org_rdata[`MPRA_BASE_MSB:`MPRA_BASE_LSB] = base_reg;
		org_rdata[`MPRA_ORG_IDX_LSB+`MPRA_IDX_W-1:`MPRA_ORG_IDX_LSB] = index_reg;
		org_rdata[`MPRA_ORG_TYPE_BIT] = type_reg;
		acc_rdata = `MPRA_RESET_WORD;
		if (USE_LIMIT != 0) begin
			acc_rdata[`MPRA_ACC_TOP:`MPRA_ACC_SIZE_LSB] = size_reg;
		end else begin
			acc_rdata[`MPRA_ACC_SIZE_MSB:`MPRA_ACC_SIZE_LSB] = size_reg[`MPRA_SIZE_W-1:0];
		end
		acc_rdata[`MPRA_ACC_CACHE_BIT] = cache_reg;
		acc_rdata[`MPRA_ACC_ACCESS_RIGHTS_MSB:`MPRA_ACC_ACCESS_RIGHTS_LSB] = rights_reg;
		acc_rdata[`MPRA_ACC_RD_BIT] = 1'b0;
		acc_rdata[`MPRA_ACC_WR_BIT] = 1'b0;
	end

	// ****************************************
	// Region matching.
	// ****************************************
	// masked or ranged hit test.
	// limit is upper bound plus one.
	function hit_fn;
		input [`MPRA_BASE_W-1:0] a_unit;
		input [`MPRA_BASE_W-1:0] b;
		input [`MPRA_LIMIT_W-1:0] s;
		begin
			if (USE_LIMIT != 0) begin
				hit_fn = ({1'b0, a_unit} >= {1'b0, b}) && ({1'b0, a_unit} < s);
			end else begin
				hit_fn = ((a_unit & s[`MPRA_SIZE_W-1:0]) == b);
			end
		end
	endfunction

	reg d_found; // A data region matched.
	reg [`MPRA_ACCESS_RIGHTS_W-1:0] d_access_rights_hit; // Rights of the lowest matching data region.
	reg d_cache_hit; // Fill flag of that region.
	reg i_found; // An instruction region matched.
	reg [`MPRA_ACCESS_RIGHTS_W-1:0] i_access_rights_hit; // Rights of the lowest matching fetch region.
	wire d_ok; // Data rights allow the access.
	wire i_ok; // Fetch rights allow the access.

	// Lowest index wins when regions overlap.
	always @* begin
		d_found = 1'b0;
		d_access_rights_hit = `MPRA_DPERM_NONE;
		d_cache_hit = 1'b0;
		for (k = NUM_DREG - 1; k >= 0; k = k - 1) begin
			if (d_valid_reg[k] &&
				hit_fn(d_addr[`MPRA_BASE_MSB:`MPRA_BASE_LSB], d_base_mem[k], d_size_mem[k])) begin
				d_found = 1'b1;
				d_access_rights_hit = d_access_rights_mem[k];
				d_cache_hit = d_cache_mem[k];
			end
		end
		i_found = 1'b0;
		i_access_rights_hit = `MPRA_IPERM_NONE;
		for (k = NUM_IREG - 1; k >= 0; k = k - 1) begin
			if (i_valid_reg[k] &&
				hit_fn(i_addr[`MPRA_BASE_MSB:`MPRA_BASE_LSB], i_base_mem[k], i_size_mem[k])) begin
				i_found = 1'b1;
				i_access_rights_hit = i_access_rights_mem[k];
			end
		end
	end

	// Data rights decoder.
	mpra_access_rights_dec u_dperm (
		.is_data(1'b1),
		.access_rights(d_access_rights_hit),
		.user_mode(i_user),
		.is_write(d_write),
		.allow(d_ok)
	);

	// Fetch rights decoder.
	mpra_access_rights_dec u_iperm (
		.is_data(1'b0),
		.access_rights(i_access_rights_hit),
		.user_mode(i_user),
		.is_write(1'b0),
		.allow(i_ok)
	);

	// ****************************************
	// Registered check results.
	// ****************************************
	always @(posedge sys_clk) begin
		if (rst) begin
			d_allow <= 1'b0;
			d_cacheable <= 1'b0;
			i_allow <= 1'b0;
		end else begin
			d_allow <= d_found && d_ok;
			i_allow <= i_found && i_ok;
			d_cacheable <= d_found && d_cache_hit && dcache_present && !d_uncached_op &&
				!d_addr[`MPRA_CACHE_BYPASS_BIT];
		end
	end

endmodule // mpra_attr
`default_nettype wire

// *** tb/mpra_attr_asserts.sv ***
// Port-level checks for the protection region attribute block.
`timescale 1ns/1ns
`default_nettype none
module mpra_attr_asserts #(
	parameter USE_LIMIT = 0 // Variant select, same as the block.
) (
	input wire logic sys_clk, // Processor clock.
	input wire logic rst, // Synchronous reset.
	input wire logic org_wr, // Origin write strobe.
	input wire logic acc_wr, // Attribute write strobe.
	input wire logic [31:0] ctl_wdata, // Write data.
	input wire logic [31:0] org_rdata, // Origin read value.
	input wire logic [31:0] acc_rdata, // Attribute read value.
	input wire logic [31:0] d_addr, // Data address.
	input wire logic d_write, // Data store.
	input wire logic d_uncached_op, // Uncached access.
	input wire logic i_user, // User mode.
	input wire logic [31:0] i_addr, // Fetch address.
	input wire logic dcache_present, // Data cache exists.
	input wire logic d_allow, // Data permitted.
	input wire logic d_cacheable, // Data cacheable.
	input wire logic i_allow // Fetch permitted.
);
	// ****************************************
	// Assertions on one clock domain.
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_trig_read_zero: assert property (acc_rdata[1:0] == 2'b00)
		else $error("trigger bits read back set");
	a_mask_top_zero: assert property (USE_LIMIT == 0 |-> acc_rdata[31] == 1'b0)
		else $error("unused top attribute bit set");
	a_inst_fill_zero: assert property (acc_wr && !ctl_wdata[1] && !org_rdata[0]
		|=> acc_rdata[5] == 1'b0)
		else $error("fill flag kept on instruction region");
	a_plain_attr_write: assert property (acc_wr && !org_wr && ctl_wdata[1:0] == 2'b00
		&& org_rdata[0] |=> acc_rdata == {(USE_LIMIT != 0) && $past(ctl_wdata[31]),
		$past(ctl_wdata[30:2]), 2'b00})
		else $error("attribute write not taken whole");
	a_org_write: assert property (org_wr && !acc_wr
		|=> org_rdata == ($past(ctl_wdata) & 32'h7fff_ffff))
		else $error("origin write not taken");
	a_uncached_bypass: assert property (d_uncached_op |=> !d_cacheable)
		else $error("uncached access marked cacheable");
	a_top_bit_bypass: assert property (d_addr[31] |=> !d_cacheable)
		else $error("top address bit did not bypass cache");
	a_no_dcache: assert property (!dcache_present |=> !d_cacheable)
		else $error("cacheable without a data cache");
	a_reset_clear: assert property ($fell(rst) |-> org_rdata == 32'h0 && acc_rdata == 32'h0
		&& !d_allow && !i_allow)
		else $error("state not cleared by reset");
endmodule // mpra_attr_asserts
bind mpra_attr mpra_attr_asserts #(.USE_LIMIT(USE_LIMIT)) u_chk (.sys_clk(sys_clk), .rst(rst),
	.org_wr(org_wr), .acc_wr(acc_wr), .ctl_wdata(ctl_wdata), .org_rdata(org_rdata),
	.acc_rdata(acc_rdata), .d_addr(d_addr), .d_write(d_write), .d_uncached_op(d_uncached_op),
	.i_user(i_user), .i_addr(i_addr), .dcache_present(dcache_present), .d_allow(d_allow),
	.d_cacheable(d_cacheable), .i_allow(i_allow));
`default_nettype wire

// *** tb/mpra_attr_test.sv ***
// Self-checking bench for the protection region attribute block.
`timescale 1ns/1ns
`default_nettype none
module mpra_attr_test;
	logic sys_clk, rst, org_wr, acc_wr, d_write, d_uncached_op, i_user, dcache_present;
	logic [31:0] ctl_wdata, d_addr, i_addr, exp_acc, lo, hi; // Stimulus and expectations.
	wire [31:0] org_rdata, acc_rdata; // Register read values.
	wire d_allow, d_cacheable, i_allow; // Access check results.
	wire [31:0] org_rdata_l, acc_rdata_l; // Limit variant read values.
	wire d_allow_l, d_cacheable_l, i_allow_l; // Limit variant check results.
	int fails, checks; // Mismatch and comparison counts.
	logic [24:0] base, mask; // Region base and size mask.
	logic [4:0] idx; // Region index.
	logic typ, fill, dc, unc; // Region type and access options.
	logic [2:0] rights; // Access rights code.
	logic [2:0] dcodes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6}; // Legal data codes.
	mpra_attr #(.USE_LIMIT(0)) uut (.sys_clk(sys_clk), .rst(rst), .org_wr(org_wr),
		.acc_wr(acc_wr), .ctl_wdata(ctl_wdata), .org_rdata(org_rdata), .acc_rdata(acc_rdata),
		.d_addr(d_addr), .d_write(d_write), .d_uncached_op(d_uncached_op), .i_user(i_user),
		.i_addr(i_addr), .dcache_present(dcache_present), .d_allow(d_allow),
		.d_cacheable(d_cacheable), .i_allow(i_allow));
	// Second copy built as the limit variant, fed the same stimulus.
	mpra_attr #(.USE_LIMIT(1)) uut_lim (.sys_clk(sys_clk), .rst(rst), .org_wr(org_wr),
		.acc_wr(acc_wr), .ctl_wdata(ctl_wdata), .org_rdata(org_rdata_l),
		.acc_rdata(acc_rdata_l), .d_addr(d_addr), .d_write(d_write),
		.d_uncached_op(d_uncached_op), .i_user(i_user), .i_addr(i_addr),
		.dcache_present(dcache_present), .d_allow(d_allow_l),
		.d_cacheable(d_cacheable_l), .i_allow(i_allow_l));
	// Clock of 20 ns period.
	always #10 sys_clk = ~sys_clk;
	// Compares one value and counts the result.
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One control-store cycle, launched and ended on falling edges.
	task wr(input logic o, input logic a, input logic [31:0] d);
		@(negedge sys_clk);
		org_wr = o;
		acc_wr = a;
		ctl_wdata = d;
		@(negedge sys_clk);
		org_wr = 1'b0;
		acc_wr = 1'b0;
	endtask
	// Programs one region entry through origin and a store trigger.
	// one trigger per write.
	task put(input logic [4:0] ix, input logic t, input logic [2:0] r, input logic f);
		wr(1'b1, 1'b0, {1'b0, base, ix, t});
		wr(1'b0, 1'b1, {1'b0, mask, f, r, 2'b01});
	endtask
	// Presents one access for a cycle; results are then settled.
	task probe(input logic [31:0] a, input logic u, input logic w, input logic un);
		d_addr = a;
		i_addr = a;
		i_user = u;
		d_write = w;
		d_uncached_op = un;
		@(negedge sys_clk);
	endtask
	// Expected attribute read value; fill is dropped for instruction regions.
	function logic [31:0] acc_exp(input logic t, input logic [24:0] m, input logic f,
		input logic [2:0] r);
		return {1'b0, m, f & t, r, 2'b00};
	endfunction
	// Expected data permission.
	function logic dperm(input logic [2:0] r, input logic u, input logic w);
		case (r)
			3'h1: return !u && !w;
			3'h2: return !w;
			3'h4: return !u;
			3'h5: return !u || !w;
			3'h6: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction
	// Ends the run with the verdict.
	task final_report;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Cuts a hang short.
	initial begin
		#2000000;
		fails++;
		final_report;
	end
	// Main sequence: register round trips, then access checks after a second reset.
	initial begin
		sys_clk = 1'b0;
		rst = 1'b1;
		{org_wr, acc_wr, d_write, d_uncached_op, i_user, dcache_present} = 6'h01;
		{ctl_wdata, d_addr, i_addr} = 96'h0;
		fails = 0;
		checks = 0;
		void'($urandom(28));
		repeat (8) @(negedge sys_clk);
		rst = 1'b0;
		chk("org reset", org_rdata, 32'h0);
		chk("org reset l", org_rdata_l, 32'h0);
		for (int i = 0; i < 24; i++) begin
			idx = 5'($urandom);
			typ = 1'($urandom);
			base = 25'($urandom);
			fill = 1'($urandom);
			mask = 25'h1ffffff << ((i < 2) ? i * 25 : $urandom_range(25));
			rights = typ ? dcodes[$urandom_range(5)] : 3'($urandom_range(2));
			exp_acc = acc_exp(typ, mask, fill, rights);
			wr(1'b1, 1'b0, {1'b0, base, idx, typ});
			wr(1'b0, 1'b1, {1'b0, mask, fill, rights, 2'b00});
			chk("acc plain", acc_rdata, exp_acc);
			chk("acc plain l", acc_rdata_l, exp_acc);
			wr(1'b0, 1'b1, {1'b1, mask, fill, rights, 2'b01});
			chk("acc store", acc_rdata, exp_acc);
			chk("acc store l", acc_rdata_l, exp_acc | 32'h8000_0000);
			wr(1'b1, 1'b0, {1'b0, ~base, idx, typ});
			wr(1'b0, 1'b1, 32'h0000_0002);
			chk("org fetch", org_rdata, {1'b0, base, idx, typ});
			chk("acc fetch", acc_rdata, exp_acc);
			chk("org fetch l", org_rdata_l, {1'b0, base, idx, typ});
			chk("acc fetch l", acc_rdata_l, exp_acc | 32'h8000_0000);
		end
		$display("round trip test done");
		rst = 1'b1;
		repeat (8) @(negedge sys_clk);
		rst = 1'b0;
		for (int j = 0; j < 6; j++) begin
			mask = 25'h1ffffff << $urandom_range(12);
			base = 25'($urandom) & mask & 25'h0ffffff;
			lo = {1'b0, base, 6'h00};
			hi = lo | {1'b0, ~mask, 6'h3f};
			fill = 1'($urandom);
			put(5'h00, 1'b1, dcodes[j], fill);
			put(5'h00, 1'b0, 3'(j % 3), 1'b1);
			chk("acc inst", acc_rdata, acc_exp(1'b0, mask, 1'b1, 3'(j % 3)));
			chk("acc inst l", acc_rdata_l, acc_exp(1'b0, mask, 1'b1, 3'(j % 3)));
			for (int k = 0; k < 4; k++) begin
				probe(k[0] ? hi : lo, k[0], k[1], 1'b0);
				chk("d_allow", 32'(d_allow), 32'(dperm(dcodes[j], k[0], k[1])));
				chk("i_allow", 32'(i_allow), 32'(j % 3 == 2 || (j % 3 == 1 && !k[0])));
				chk("d_allow l", 32'(d_allow_l), 32'(dperm(dcodes[j], k[0], k[1])));
				chk("i_allow l", 32'(i_allow_l), 32'(j % 3 == 2 || (j % 3 == 1 && !k[0])));
			end
			probe(hi + 32'h1, 1'b0, 1'b0, 1'b0);
			chk("d_allow out", 32'(d_allow), 32'h0);
			chk("d_allow l in", 32'(d_allow_l), 32'(dperm(dcodes[j], 1'b0, 1'b0)));
			probe({1'b0, mask - 25'h1, 6'h3f}, 1'b0, 1'b0, 1'b0);
			chk("d_allow below", 32'(d_allow), 32'h0);
			chk("d_allow l below", 32'(d_allow_l), 32'(dperm(dcodes[j], 1'b0, 1'b0)));
			probe({1'b0, mask, 6'h00}, 1'b0, 1'b0, 1'b0);
			chk("d_allow limit", 32'(d_allow), 32'h0);
			chk("d_allow l limit", 32'(d_allow_l), 32'h0);
			unc = 1'($urandom);
			dc = 1'($urandom);
			dcache_present = dc;
			probe(lo, 1'b0, 1'b0, unc);
			chk("d_cacheable", 32'(d_cacheable), 32'(dc & !unc & fill));
			chk("d_cacheable l", 32'(d_cacheable_l), 32'(dc & !unc & fill));
			dcache_present = 1'b1;
			probe({1'b1, lo[30:0]}, 1'b0, 1'b0, 1'b0);
			chk("bypass", 32'(d_cacheable), 32'h0);
			chk("bypass l", 32'(d_cacheable_l), 32'h0);
		end
		$display("access test done");
		final_report;
	end
endmodule // mpra_attr_test
`default_nettype wire
